// ---- sim/smbs_ctl.sv ----
`default_nettype none
module smbs_ctl
  import smbs_pkg::*;
#(
  parameter int MRD = 2
)(
  input wire logic clk,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [ADDR_W-1:0] addr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    addr = 13'h0000;
  end
  // deselect after each command so nothing is taken twice
  task automatic issue(input logic [3:0] c, input logic [11:0] a);
    @(posedge clk);
    {cs_n, ras_n, cas_n, we_n} <= c;
    addr <= {1'b0, a};
    @(posedge clk);
    {cs_n, ras_n, cas_n, we_n} <= 4'hf;
  endtask : issue
  task automatic load(input logic [11:0] m);
    issue(CMD_LMR, m);
    repeat (MRD)
      issue(CMD_NOP, 12'h000);
  endtask : load
endmodule : smbs_ctl
`default_nettype wire

// ---- sim/smbs_seq_props.sv ----
`default_nettype none
module smbs_seq_props
  import smbs_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic busy,
  input wire logic dq_drive,
  input wire logic dq_valid,
  input wire logic mode_reserved,
  input wire logic [MODE_W-1:0] mode_word
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  logic sel, lmr, rw, rd, nop, lat_ok, rsv;
  logic [2:0] rl;
  assign sel = cke && !cs_n;
  assign lmr = sel && {ras_n, cas_n, we_n} == CMD_LMR[2:0];
  assign rw = sel && ras_n && !cas_n;
  assign rd = rw && we_n;
  assign nop = sel && {ras_n, cas_n, we_n} == CMD_NOP[2:0];
  assign rl = mode_word[RL_MSB:RL_LSB];
  assign lat_ok = rl inside {RL_TWO, RL_THREE};
  assign rsv = !lat_ok || mode_word[OPM_HI_BIT:OPM_LO_BIT] != 2'h0 ||
    !(mode_word[BL_MSB:BL_LSB] inside {BL_ONE, BL_TWO, BL_FOUR, BL_EIGHT,
    BL_PAGE}) ||
    (mode_word[BL_MSB:BL_LSB] == BL_PAGE && mode_word[BO_BIT]);
  // output turn-on then first valid data, one cycle apart
  sequence s_dq;
    dq_drive ##1 dq_valid;
  endsequence
  sequence s_idle;
    !rw ##1 !busy;
  endsequence
  AST_LOAD: assert property (lmr |=> mode_word == $past(addr[11:0]))
    else $error("mode word not loaded from address");
  AST_HOLD: assert property (!lmr |=> $stable(mode_word))
    else $error("mode word changed without load");
  AST_RSV_FLAG: assert property (lmr ##1 !lmr |=> mode_reserved == rsv)
    else $error("reserved flag disagrees with mode word");
  AST_LAT2: assert property (rd && !mode_reserved && rl == RL_TWO
    |-> ##1 !dq_drive ##1 s_dq) else $error("latency two timing wrong");
  AST_LAT3: assert property (rd && !mode_reserved && rl == RL_THREE
    |-> ##2 !dq_drive ##1 s_dq) else $error("latency three timing wrong");
  AST_RSV_LAT: assert property (rd && !lat_ok |=> !dq_drive[*5])
    else $error("data driven with reserved latency");
  AST_INHIBIT: assert property (s_idle ##0 !sel |=> !busy)
    else $error("deselected device started work");
  AST_NOP: assert property (s_idle ##0 nop |=> !busy)
    else $error("no-operation started work");
endmodule : smbs_seq_props
bind smbs_seq smbs_seq_props u_props (.clk(clk), .rstn(rstn), .cke(cke),
  .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr),
  .busy(busy), .dq_drive(dq_drive), .dq_valid(dq_valid),
  .mode_reserved(mode_reserved), .mode_word(mode_word));
`default_nettype wire

// ---- sim/tb.sv ----
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("BAD %s exp %h got %h", nm, e, g); \
    end \
  end
module tb
  import smbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, col_ready, cke, cs_n, ras_n, cas_n, we_n;
  logic col_valid, col_is_write, busy, cmd_ready, dq_drive, dq_valid;
  logic mode_reserved;
  logic [ADDR_W-1:0] addr;
  logic [COL_W-1:0] col_addr;
  logic [MODE_W-1:0] mode_word;
  logic [9:0] exp_v;
  logic [9:0] exp_q[$];
  int bad_count, check_count, cycles;
  smbs_ctl #(.MRD(2)) u_ctl (.clk(clk), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr));
  smbs_seq #(.FIFO_DEPTH(8)) dut (.clk(clk), .rstn(rstn), .cke(cke),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr),
    .col_ready(col_ready), .col_valid(col_valid), .col_addr(col_addr),
    .col_is_write(col_is_write), .busy(busy), .cmd_ready(cmd_ready),
    .dq_drive(dq_drive), .dq_valid(dq_valid),
    .mode_reserved(mode_reserved), .mode_word(mode_word));
  initial
  begin
    clk = 1'b0;
    forever
      #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (col_valid === 1'b1 && col_ready === 1'b1 && exp_q.size() != 0)
    begin
      exp_v = exp_q.pop_front();
      `CHK("column", exp_v, {col_is_write, col_addr})
    end
    else if (col_valid === 1'b1 && col_ready === 1'b1)
      `CHK("extra column", 1'b0, col_valid)
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      summarize();
    end
  end
  function automatic logic [11:0] mw(input logic [2:0] bl, input logic bo,
    input logic [2:0] rl, input logic ws);
    return {2'h0, ws, 2'h0, rl, bo, bl};
  endfunction : mw
  // expected order: xor for interleaved, add within the block otherwise
  task automatic want(input logic [9:0] s, input int cnt, input int len,
    input logic il);
    logic [9:0] m;
    m = 10'(len - 1);
    for (int i = 0; i < cnt; i++)
      exp_q.push_back(il ? s ^ 10'(i) : (s & ~m) | ((s + 10'(i)) & m));
  endtask : want
  task automatic mode(input logic [11:0] m);
    u_ctl.load(m);
    `CHK("mode word", m, mode_word)
  endtask : mode
  task automatic run(input logic [3:0] c, input logic [11:0] a);
    u_ctl.issue(c, a);
    repeat (60)
      if (exp_q.size() != 0)
        @(posedge clk);
    `CHK("columns left", 0, exp_q.size())
    repeat (6)
      @(posedge clk);
  endtask : run
  task automatic summarize();
    if (bad_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  initial
  begin
    rstn = 1'b0;
    col_ready = 1'b1;
    bad_count = 0;
    check_count = 0;
    cycles = 0;
    repeat (5)
      @(posedge clk);
    rstn <= 1'b1;
    mode(mw(BL_FOUR, 1'b0, RL_THREE, 1'b0));
    want(10'h105, 4, 4, 1'b0);
    run(CMD_READ, 12'h105);
    mode(mw(BL_EIGHT, 1'b1, RL_TWO, 1'b0));
    want(10'h0fb, 8, 8, 1'b1);
    u_ctl.issue(CMD_READ, 12'h0fb);
    run(CMD_NOP, 12'h000);
    mode(mw(BL_TWO, 1'b0, RL_TWO, 1'b0));
    want(10'h011, 2, 2, 1'b0);
    run(CMD_READ, 12'h011);
    run(4'hd, 12'h011);
    mode(mw(BL_ONE, 1'b1, RL_TWO, 1'b0));
    want(10'h1a5, 1, 1, 1'b1);
    run(CMD_READ, 12'h1a5);
    mode(mw(BL_FOUR, 1'b0, RL_TWO, 1'b1));
    want(10'h232, 1, 1, 1'b0);
    run(CMD_WRITE, 12'h032);
    want(10'h032, 4, 4, 1'b0);
    run(CMD_READ, 12'h032);
    mode(mw(BL_TWO, 1'b0, RL_TWO, 1'b0));
    want(10'h241, 2, 2, 1'b0);
    run(CMD_WRITE, 12'h041);
    mode(mw(3'h4, 1'b0, RL_TWO, 1'b0));
    `CHK("reserved length", 1'b1, mode_reserved)
    run(CMD_READ, 12'h010);
    mode(mw(BL_TWO, 1'b0, 3'h5, 1'b0));
    `CHK("reserved latency", 1'b1, mode_reserved)
    want(10'h010, 2, 2, 1'b0);
    run(CMD_READ, 12'h010);
    mode(mw(BL_PAGE, 1'b0, RL_THREE, 1'b0));
    col_ready <= 1'b0;
    // ten words fill fifo and output stage; one more enters as the
    // terminate is taken
    want(10'h1ff, 11, 512, 1'b0);
    u_ctl.issue(CMD_READ, 12'h1ff);
    repeat (20)
      @(posedge clk);
    `CHK("buffer full", 1'b0, cmd_ready)
    col_ready <= 1'b1;
    run(CMD_TERM, 12'h000);
    summarize();
  end
endmodule : tb
`default_nettype wire

// ---- src/smbs_fifo.sv ----
`default_nettype none
module smbs_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
)(
  input wire logic clk,
  input wire logic rstn,
  smbs_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic [WIDTH-1:0] rd_q, rd_d;
  logic ov_q, ov_d;
  logic push, pop;
  // output word held in a register; pop refills it from memory
  always_comb
  begin
    push = f.in_valid && (cnt_q < (AW+1)'(DEPTH));
    pop = (!ov_q || f.out_ready) && (cnt_q != '0);
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    rd_d = pop ? mem_q[rp_q] : rd_q;
    ov_d = pop ? 1'b1 : (f.out_ready ? 1'b0 : ov_q);
  end
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      rd_q <= '0;
      ov_q <= 1'b0;
    end
    else
    begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      rd_q <= rd_d;
      ov_q <= ov_d;
    end
    if (push)
      mem_q[wp_q] <= f.in_data;
  end
  assign f.in_ready = cnt_q < (AW+1)'(DEPTH);
  assign f.out_valid = ov_q;
  assign f.out_data = rd_q;
endmodule : smbs_fifo
`default_nettype wire

// ---- src/smbs_fifo_if.sv ----
`default_nettype none
interface smbs_fifo_if #(parameter int W = 11);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport src (output in_valid, output in_data, input in_ready,
    input out_valid, input out_data, output out_ready);
  modport fifo (input in_valid, input in_data, output in_ready,
    output out_valid, output out_data, input out_ready);
endinterface : smbs_fifo_if
`default_nettype wire

// ---- src/smbs_pkg.sv ----
`default_nettype none
package smbs_pkg;
  localparam int COL_W = 9;
  localparam int ADDR_W = 13;
  localparam int MODE_W = 12;
  // mode register field layout
  localparam int BL_LSB = 0;
  localparam int BL_MSB = 2;
  localparam int BO_BIT = 3;
  localparam int RL_LSB = 4;
  localparam int RL_MSB = 6;
  localparam int OPM_LO_BIT = 7;
  localparam int OPM_HI_BIT = 8;
  localparam int WS_BIT = 9;
  // burst length codes
  localparam logic [2:0] BL_ONE = 3'h0;
  localparam logic [2:0] BL_TWO = 3'h1;
  localparam logic [2:0] BL_FOUR = 3'h2;
  localparam logic [2:0] BL_EIGHT = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  // read latency codes
  localparam logic [2:0] RL_TWO = 3'h2;
  localparam logic [2:0] RL_THREE = 3'h3;
  localparam logic [1:0] LAT_TWO = 2'h2;
  localparam logic [1:0] LAT_THREE = 2'h3;
  localparam logic [9:0] PAGE_LEN = 10'h200;
  localparam logic [9:0] ONE_LEN = 10'h001;
  localparam logic [9:0] TWO_LEN = 10'h002;
  localparam logic [9:0] FOUR_LEN = 10'h004;
  localparam logic [9:0] EIGHT_LEN = 10'h008;
  localparam logic [MODE_W-1:0] MODE_RESET = 12'h000;
  // command codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_TERM = 4'h6;
  localparam logic [3:0] CMD_LMR = 4'h0;
  typedef enum logic [1:0]
  {
    SMBS_IDLE = 2'h0,
    SMBS_RUN = 2'h1,
    SMBS_LAST = 2'h3
  } smbs_state_type;
endpackage : smbs_pkg
`default_nettype wire

// ---- src/smbs_seq.sv ----
// What this block does
// - lengths 1,2,4,8 both orders; page sequential only
// - burst length caps accesses per command
// - upper column bits pick the block
// - burst wraps inside its own block
// - page burst wraps within 512 columns
// - order bit: zero sequential, one interleaved
// - sequential offset increments modulo length
// - interleaved offset is count xor start
// - length one uses column, ignores order
// - read data drives at n+m-1, valid n+m
// - only latency two or three drive read data; other codes still run the column burst
// - write single bit forces one-location writes
// - deselected chip executes nothing new
// - no-operation registers nothing, burst continues
// - load-mode captures address bits 0 to 11
// - mode fields at their fixed bit positions
// - mode register holds until reloaded
`default_nettype none
module smbs_seq
  import smbs_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
)(
  input wire logic clk,
  input wire logic rstn,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic col_ready,
  output logic col_valid,
  output logic [COL_W-1:0] col_addr,
  output logic col_is_write,
  output logic busy,
  output logic cmd_ready,
  output logic dq_drive,
  output logic dq_valid,
  output logic mode_reserved,
  output logic [MODE_W-1:0] mode_word
);
  // ****************************************************************
  // mode register
  // ****************************************************************
  logic [MODE_W-1:0] mode_q, mode_d;
  logic [3:0] cmd;
  logic cmd_live, is_lmr, is_read, is_write, is_term;
  logic [2:0] bl_code, rl_code;
  logic bl_ok, rl_ok;
  always_comb
  begin
    cmd = {cs_n, ras_n, cas_n, we_n};
    // clock enable low is taken as no command as well
    cmd_live = !cs_n && cke;
    is_lmr = cmd_live && cmd == CMD_LMR;
    is_read = cmd_live && cmd == CMD_READ;
    is_write = cmd_live && cmd == CMD_WRITE;
    is_term = cmd_live && cmd == CMD_TERM;
    mode_d = is_lmr ? addr[MODE_W-1:0] : mode_q;
    bl_code = mode_q[BL_MSB:BL_LSB];
    rl_code = mode_q[RL_MSB:RL_LSB];
  end
  always_ff @(posedge clk)
  begin
    // reset only gives simulation a defined start; reload is required
    if (!rstn)
      mode_q <= MODE_RESET;
    else
      mode_q <= mode_d;
  end

  // ****************************************************************
  // mode decode
  // ****************************************************************
  logic [9:0] len;
  logic order_il;
  logic [8:0] blk_mask;
  always_comb
  begin
    order_il = mode_q[BO_BIT];
    bl_ok = 1'b1;
    case (bl_code)
      BL_ONE: len = ONE_LEN;
      BL_TWO: len = TWO_LEN;
      BL_FOUR: len = FOUR_LEN;
      BL_EIGHT: len = EIGHT_LEN;
      BL_PAGE:
      begin
        len = PAGE_LEN;
        bl_ok = !order_il;
      end
      default:
      begin
        len = ONE_LEN;
        bl_ok = 1'b0;
      end
    endcase
    // a reserved latency code leaves reads without any data phase
    rl_ok = rl_code == RL_TWO || rl_code == RL_THREE;
    blk_mask = 9'(len - 10'h001);
  end

  // ****************************************************************
  // column burst engine
  // ****************************************************************
  smbs_state_type st_q, st_d;
  logic [COL_W-1:0] base_q, base_d, start_q, start_d;
  logic [COL_W-1:0] cnt_q, cnt_d, mask_q, mask_d;
  logic il_q, il_d, wr_q, wr_d;
  logic [9:0] left_q, left_d;
  logic [COL_W-1:0] off, col;
  logic push_ok, start_burst, step;
  logic col_take;
  smbs_fifo_if #(.W(COL_W + 1)) fq ();
  always_comb
  begin
    push_ok = fq.in_ready;
    start_burst = (is_read || is_write) && bl_ok;
    st_d = st_q;
    base_d = base_q;
    start_d = start_q;
    cnt_d = cnt_q;
    mask_d = mask_q;
    il_d = il_q;
    wr_d = wr_q;
    left_d = left_q;
    // offset inside the block; engine stalls while fifo is full
    off = il_q ? ((cnt_q ^ start_q) & mask_q)
               : ((cnt_q + start_q) & mask_q);
    col = (base_q & ~mask_q) | off;
    step = st_q != SMBS_IDLE && push_ok;
    // a new read or write restarts the burst; the word pushed in this
    // cycle still belongs to the burst that it cuts short
    if (start_burst)
    begin
      base_d = addr[COL_W-1:0];
      start_d = addr[COL_W-1:0];
      cnt_d = '0;
      wr_d = is_write;
      // single-location write, or length one ignoring the order bit
      if (is_write && mode_q[WS_BIT])
      begin
        mask_d = '0;
        left_d = ONE_LEN;
      end
      else
      begin
        mask_d = blk_mask;
        left_d = len;
      end
      il_d = order_il && bl_code != BL_ONE;
      st_d = SMBS_RUN;
    end
    else if (is_term && st_q != SMBS_IDLE)
      st_d = SMBS_IDLE;
    else if (step)
    begin
      cnt_d = cnt_q + 9'h001;
      left_d = left_q - 10'h001;
      if (left_q == 10'h002)
        st_d = SMBS_LAST;
      else if (left_q == ONE_LEN)
        st_d = SMBS_IDLE;
    end
    fq.in_valid = step;
    fq.in_data = {wr_q, col};
    col_take = !col_valid || col_ready;
    fq.out_ready = col_take;
  end
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      st_q <= SMBS_IDLE;
      base_q <= '0;
      start_q <= '0;
      cnt_q <= '0;
      mask_q <= '0;
      il_q <= 1'b0;
      wr_q <= 1'b0;
      left_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      base_q <= base_d;
      start_q <= start_d;
      cnt_q <= cnt_d;
      mask_q <= mask_d;
      il_q <= il_d;
      wr_q <= wr_d;
      left_q <= left_d;
    end
  end

  // depth only trades stall cycles for area; column order is unaffected
  smbs_fifo #(.WIDTH(COL_W + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .f(fq.fifo)
  );

  // ****************************************************************
  // read latency pipe
  // ****************************************************************
  logic [LAT_THREE:0] rd_pipe_q, rd_pipe_d;
  logic [1:0] lat;
  logic drive_d, valid_d;
  always_comb
  begin
    // reserved codes index as two, but rl_ok keeps such reads out of
    // the pipe, so they never drive
    lat = rl_code == RL_THREE ? LAT_THREE : LAT_TWO;
    // bit k set: a read was registered k edges before this edge
    rd_pipe_d = {rd_pipe_q[LAT_THREE-1:0], is_read && rl_ok};
    // drive is registered at edge n+m-1, valid at edge n+m
    drive_d = rd_pipe_d[lat - 2'h1];
    valid_d = rd_pipe_d[lat];
  end
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rd_pipe_q <= '0;
      dq_drive <= 1'b0;
      dq_valid <= 1'b0;
    end
    else
    begin
      rd_pipe_q <= rd_pipe_d;
      dq_drive <= drive_d;
      dq_valid <= valid_d;
    end
  end

  // ****************************************************************
  // column output stage
  // ****************************************************************
  logic col_valid_d, col_is_write_d;
  logic [COL_W-1:0] col_addr_d;
  always_comb
  begin
    // a full stage reloads only once its word is taken, so a stalled
    // consumer neither loses nor sees twice any column
    col_valid_d = col_take ? fq.out_valid : col_valid;
    col_addr_d = col_take ? fq.out_data[COL_W-1:0] : col_addr;
    col_is_write_d = col_take ? fq.out_data[COL_W] : col_is_write;
  end
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      col_valid <= 1'b0;
      col_addr <= '0;
      col_is_write <= 1'b0;
    end
    else
    begin
      col_valid <= col_valid_d;
      col_addr <= col_addr_d;
      col_is_write <= col_is_write_d;
    end
  end

  // ****************************************************************
  // status outputs
  // ****************************************************************
  logic busy_d, cmd_ready_d, reserved_d;
  always_comb
  begin
    busy_d = st_d != SMBS_IDLE;
    // fifo room, not engine state: a full fifo stalls the burst
    cmd_ready_d = fq.in_ready;
    // flags settings that the controller must never program
    reserved_d = !(bl_ok && rl_ok) || mode_q[OPM_LO_BIT] ||
      mode_q[OPM_HI_BIT];
  end
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      busy <= 1'b0;
      cmd_ready <= 1'b0;
      mode_reserved <= 1'b0;
      mode_word <= MODE_RESET;
    end
    else
    begin
      busy <= busy_d;
      cmd_ready <= cmd_ready_d;
      mode_reserved <= reserved_d;
      mode_word <= mode_d;
    end
  end
endmodule : smbs_seq
`default_nettype wire
